// [src/coeff_bank_pkg.sv]
// Constants for the DTMF threshold and oscillator coefficient bank.
// Assumes a 32-bit APB slave; each 16-bit location takes one aligned word.
package coeff_bank_pkg;
    localparam int unsigned WORD_W    = 16;
    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned FIRST_IDX = 7;
    localparam int unsigned LAST_IDX  = 25;
    localparam int unsigned NUM_LOC   = LAST_IDX - FIRST_IDX + 1;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_ROW_REL   = 6'h07;
    localparam logic [5:0] IDX_COL_REL   = 6'h08;
    localparam logic [5:0] IDX_ROW_HARM  = 6'h09;
    localparam logic [5:0] IDX_COL_HARM  = 6'h0A;
    localparam logic [5:0] IDX_MIN_PWR   = 6'h0B;
    localparam logic [5:0] IDX_AGC_HOT   = 6'h0C;
    localparam logic [5:0] IDX_T1_FREQ   = 6'h0D;
    localparam logic [5:0] IDX_T1_AMP    = 6'h0E;
    localparam logic [5:0] IDX_T1_PHASE  = 6'h0F;
    localparam logic [5:0] IDX_T2_FREQ   = 6'h10;
    localparam logic [5:0] IDX_T2_AMP    = 6'h11;
    localparam logic [5:0] IDX_T2_PHASE  = 6'h12;
    localparam logic [5:0] IDX_RING_OFS  = 6'h13;
    localparam logic [5:0] IDX_RING_FREQ = 6'h14;
    localparam logic [5:0] IDX_RING_AMP  = 6'h15;
    localparam logic [5:0] IDX_RING_PH   = 6'h16;
    localparam logic [5:0] IDX_MET_RAMP  = 6'h17;
    localparam logic [5:0] IDX_MET_AMP   = 6'h18;
    localparam logic [5:0] IDX_MET_FREQ  = 6'h19;
    // Ratio code for unity and the offset field
    localparam logic [15:0] RATIO_UNITY  = 16'h07F0;
    localparam int unsigned OFS_LSB      = 0;
    localparam int unsigned OFS_W        = 6;
    localparam logic [WORD_W-1:0] INIT_VALUE = 16'h0000;
endpackage

// [src/coeff_bank.sv]
// Holds DTMF detector thresholds and tone/ring/metering coefficients.
// Assumes an APB master on i_mclk and synchronous inputs.
//
// Operation
// - Row peak versus other rows uses row relative threshold; 0x7F0 is one.
// - Column peak versus other columns uses column threshold; 0x7F0 is one.
// - Peak row against its second harmonic uses row harmonic threshold.
// - Peak column against its second harmonic uses column harmonic threshold.
// - Evaluations below the minimum power threshold are discarded.
// - The hot limit value drives the two-step DTMF AGC.
// - Oscillator values are signed two's complement.
// - Locations are cleared to zero by reset; host programs them.
// - Tone one uses locations 13, 14 and 15.
// - Tone two uses locations 16, 17 and 18.
// - Ringing DC offset is six bits, 1.5 V steps to 94.5 V.
// - Ringing generator uses locations 20, 21 and 22.
// - Metering uses ramp at 23, amplitude 24, frequency 25.
`timescale 1ns/1ps
`default_nettype none
module coeff_bank #(
    parameter int unsigned WORD_W = coeff_bank_pkg::WORD_W
) (
    input  wire logic               i_mclk,
    input  wire logic               i_rst_b,
    input  wire logic               i_ce,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    output logic signed [15:0]      o_row_relative_threshold,
    output logic signed [15:0]      o_column_relative_threshold,
    output logic signed [15:0]      o_row_harmonic_threshold,
    output logic signed [15:0]      o_column_harmonic_threshold,
    output logic signed [15:0]      o_minimum_power_threshold,
    output logic signed [15:0]      o_agc_hot_limit,
    output logic signed [15:0]      o_tone1_frequency,
    output logic signed [15:0]      o_tone1_amplitude,
    output logic signed [15:0]      o_tone1_phase,
    output logic signed [15:0]      o_tone2_frequency,
    output logic signed [15:0]      o_tone2_amplitude,
    output logic signed [15:0]      o_tone2_phase,
    output logic        [5:0]       o_ringing_offset,
    output logic signed [15:0]      o_ringing_frequency,
    output logic signed [15:0]      o_ringing_amplitude,
    output logic signed [15:0]      o_ringing_phase,
    output logic signed [15:0]      o_metering_ramp,
    output logic signed [15:0]      o_metering_amplitude,
    output logic signed [15:0]      o_metering_frequency
);
    localparam int unsigned N = coeff_bank_pkg::NUM_LOC;

    logic [WORD_W-1:0] loc_r [N];
    logic [5:0]        idx;
    logic              hit;
    logic [4:0]        slot;
    logic              wr_en;
    logic [31:0]       prdata_r;
    logic              err_r;

    // Word index from the byte address; only aligned locations 7..25 decode
    assign idx  = paddr[7:2];
    assign hit  = (paddr[1:0] == 2'h0)
               && (idx >= coeff_bank_pkg::IDX_ROW_REL)
               && (idx <= coeff_bank_pkg::IDX_MET_FREQ);
    assign slot = 5'(idx - coeff_bank_pkg::IDX_ROW_REL);
    assign wr_en = i_ce && psel && penable && pwrite && hit;

    // Zero wait states; an access phase completes while enabled
    assign pready  = i_ce;
    assign pslverr = err_r;
    assign prdata  = prdata_r;

    // Storage carries all 16 bits, reserved positions included
    // Reset clears to a defined value; software must still program all
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_loc
            always_ff @(posedge i_mclk) begin
                if (!i_rst_b) begin
                    loc_r[g] <= coeff_bank_pkg::INIT_VALUE;
                end else if (wr_en && slot == 5'(g)) begin
                    loc_r[g] <= pwdata[WORD_W-1:0];
                end
            end
        end
    endgenerate

    // Read data and error registered in the setup phase
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            prdata_r <= 32'h0000_0000;
            err_r    <= 1'b0;
        end else if (i_ce && psel && !penable) begin
            err_r <= !hit;
            if (hit && !pwrite) begin
                prdata_r <= {16'h0000, loc_r[slot]};
            end else begin
                prdata_r <= 32'h0000_0000;
            end
        end
    end

    // Detector thresholds, unity ratio at the unity code
    assign o_row_relative_threshold    = loc_r[0];
    assign o_column_relative_threshold = loc_r[1];
    assign o_row_harmonic_threshold    = loc_r[2];
    assign o_column_harmonic_threshold = loc_r[3];
    assign o_minimum_power_threshold   = loc_r[4];
    assign o_agc_hot_limit             = loc_r[5];
    // Oscillator coefficients, signed; ringing offset is an unsigned six-bit field
    assign o_tone1_frequency    = loc_r[6];
    assign o_tone1_amplitude    = loc_r[7];
    assign o_tone1_phase        = loc_r[8];
    assign o_tone2_frequency    = loc_r[9];
    assign o_tone2_amplitude    = loc_r[10];
    assign o_tone2_phase        = loc_r[11];
    assign o_ringing_offset     =
        loc_r[12][coeff_bank_pkg::OFS_LSB +: coeff_bank_pkg::OFS_W];
    assign o_ringing_frequency  = loc_r[13];
    assign o_ringing_amplitude  = loc_r[14];
    assign o_ringing_phase      = loc_r[15];
    assign o_metering_ramp      = loc_r[16];
    assign o_metering_amplitude = loc_r[17];
    assign o_metering_frequency = loc_r[18];

    // Assertions
    sequence s_write_row;
        psel && penable && pwrite && i_ce && hit
            && idx == coeff_bank_pkg::IDX_ROW_REL;
    endsequence

    chk_row_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        s_write_row |=> o_row_relative_threshold == $past(pwdata[15:0]))
        else $error("row threshold not stored");
    chk_col_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_COL_REL
        |=> o_column_relative_threshold == $past(pwdata[15:0]))
        else $error("column threshold not stored");
    chk_harm_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_ROW_HARM
        |=> o_row_harmonic_threshold == $past(pwdata[15:0]))
        else $error("row harmonic not stored");
    chk_colh_write: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_COL_HARM
        |=> o_column_harmonic_threshold == $past(pwdata[15:0]))
        else $error("column harmonic not stored");
    chk_tone1_amp: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_T1_AMP
        |=> o_tone1_amplitude == $past(pwdata[15:0]))
        else $error("tone one amplitude wrong");
    chk_tone2_ph: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_T2_PHASE
        |=> o_tone2_phase == $past(pwdata[15:0]))
        else $error("tone two phase wrong");
    chk_ring_ofs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_RING_OFS
        |=> o_ringing_offset == $past(pwdata[5:0]))
        else $error("ringing offset wrong");
    chk_ring_freq: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_RING_FREQ
        |=> o_ringing_frequency == $past(pwdata[15:0]))
        else $error("ringing frequency wrong");
    chk_met_ramp: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_MET_RAMP
        |=> o_metering_ramp == $past(pwdata[15:0]))
        else $error("metering ramp wrong");
    chk_read_back: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        i_ce && psel && !penable && !pwrite && hit
        |=> prdata == {16'h0000, $past(loc_r[slot])})
        else $error("read data mismatch");
    chk_min_power: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !wr_en |=> $stable(o_minimum_power_threshold))
        else $error("minimum power changed without write");
    chk_hot_limit: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        wr_en && idx == coeff_bank_pkg::IDX_AGC_HOT
        |=> o_agc_hot_limit == $past(pwdata[15:0]))
        else $error("hot limit not stored");
endmodule
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the coefficient bank over APB.
// Assumes pready follows i_ce and a read answers with zero wait states.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic               i_mclk, i_rst_b, i_ce, psel, penable, pwrite;
    logic               pready, pslverr, er;
    logic        [7:0]  paddr;
    logic        [31:0] pwdata, prdata, rd;
    logic signed [15:0] o_row_relative_threshold, o_column_relative_threshold,
        o_row_harmonic_threshold, o_column_harmonic_threshold,
        o_minimum_power_threshold, o_agc_hot_limit, o_tone1_frequency,
        o_tone1_amplitude, o_tone1_phase, o_tone2_frequency, o_tone2_amplitude,
        o_tone2_phase, o_ringing_frequency, o_ringing_amplitude,
        o_ringing_phase, o_metering_ramp, o_metering_amplitude,
        o_metering_frequency;
    logic        [5:0]  o_ringing_offset;
    logic        [15:0] outs [7:25];
    int                 bad_count, checks_done, i;

    coeff_bank u_dut (.*);

    // Output ports indexed by location
    always_comb outs = '{o_row_relative_threshold, o_column_relative_threshold,
        o_row_harmonic_threshold, o_column_harmonic_threshold,
        o_minimum_power_threshold, o_agc_hot_limit, o_tone1_frequency,
        o_tone1_amplitude, o_tone1_phase, o_tone2_frequency, o_tone2_amplitude,
        o_tone2_phase, {10'h000, o_ringing_offset}, o_ringing_frequency,
        o_ringing_amplitude, o_ringing_phase, o_metering_ramp,
        o_metering_amplitude, o_metering_frequency};

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_mclk);
        penable <= 1'b1;
        @(posedge i_mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge i_mclk);
        end
        if (n == 20) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Signed pattern per location, sign bit set
    function automatic logic [15:0] val(input int k);
        return 16'h8000 | 16'(k * 16'h0111);
    endfunction

    task automatic t_map();
        for (i = 7; i <= 25; i++) apb(1'b1, 8'(i * 4), {16'hDEAD, val(i)});
        @(negedge i_mclk);
        for (i = 7; i <= 25; i++)
            chk("output", i == 19 ? val(i) & 16'h003F : val(i), outs[i]);
        for (i = 7; i <= 25; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk("readback", {16'h0000, val(i)}, rd);
            chk("error", 32'h0, {31'h0, er});
        end
    endtask

    task automatic t_reserved();
        apb(1'b1, 8'h4C, 32'h0000_FFFF);
        @(negedge i_mclk);
        chk("offset", 32'h3F, {16'h0000, outs[19]});
        apb(1'b0, 8'h4C, 32'h0);
        chk("reserved", 32'h0000_FFFF, rd);
    endtask

    task automatic t_refuse();
        logic [7:0] bad_a [3] = '{8'h18, 8'h68, 8'h1D};
        foreach (bad_a[k]) begin
            apb(1'b1, bad_a[k], 32'h0000_1234);
            apb(1'b0, bad_a[k], 32'h0);
            chk("bad read", 32'h0, rd);
            chk("bad error", 32'h1, {31'h0, er});
        end
        chk("kept", {16'h0000, val(7)}, {16'h0000, outs[7]});
    endtask

    task automatic t_ce();
        @(posedge i_mclk);
        i_ce <= 1'b0;
        @(negedge i_mclk);
        chk("stalled", 32'h0, {31'h0, pready});
        chk("frozen", {16'h0000, val(25)}, {16'h0000, outs[25]});
        @(posedge i_mclk);
        i_ce <= 1'b1;
    endtask

    initial begin
        {i_rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        i_ce = 1'b1;
        repeat (4) @(posedge i_mclk);
        i_rst_b <= 1'b1;
        t_map();
        t_reserved();
        t_refuse();
        t_ce();
        tally_and_finish();
    end

    initial begin
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
